// >>> core/amp_seq_map.vh
`ifndef AMP_SEQ_MAP_VH
`define AMP_SEQ_MAP_VH
// ****************************************
// Timing
// ****************************************
`define CLK_KHZ 20000
`define T_RESTART_MS 100
`define T_FLAG_MS 50
`define T_CHECK_CYC 8'd16
// ****************************************
// Register offsets and fields
// ****************************************
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define RATE_OFS 12'h008
`define CTRL_HOLD 0
`define CTRL_BACKOFF 1
`define CTRL_MASK 32'h0000_0003
`define CTRL_RST 32'h0000_0002
// ****************************************
// Modes
// ****************************************
`define MODE_SLEEP 2'h0
`define MODE_MUTE 2'h1
`define MODE_OPER 2'h2
`define MODE_FAULT 2'h3
// ****************************************
// Carrier, gain and bias
// ****************************************
`define CAR_K 19'h0066d
`define CAR_MIN 9'h028
`define CAR_MAX 9'h042
`define MASTER_MIN_KOHM 8'h19
`define GAIN_MAX 8'hff
`define GAIN_MIN 8'h20
`define BIAS_MAX 8'hff
`endif

// >>> core/sync_2ff.v
`timescale 1ns/1ns
// ****************************************
// Two-stage level synchroniser
// ****************************************
module sync_2ff #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Data
   input wire [W-1:0] d,
   output reg [W-1:0] q
);
   reg [W-1:0] meta_q;

   // First stage feeds only the second
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// >>> core/amp_mode_protection_sequencer.v
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`include "amp_seq_map.vh"
// Summary of operation
// R1: Host picks Sleep, Mute or Operating through wake and unmute pins, and Fault through the fault line.
// R2: Wake low sleeps; wake high mutes; both high operate; low fault line faults.
// R3: Mute keeps stages switching at half duty with converters disabled.
// R4: Operating runs both channels with modulated audio.
// R5: Converter bias zero in Mute, maximum in Operating; host ramps unmute slowly.
// R6: Carrier 300 to 500 kHz, set by resistor as 12.45e9 over resistance.
// R7: Resistor above 25k makes master driving sync; shorted makes slave.
// R8: Above 140 C gain backs off gradually, device keeps running.
// R9: Above 155 C the power stage shuts down at once.
// R10: Current above 2 A from impedance drop is limited, audio continues.
// R11: Fault overcurrent switches off and holds stage off at least 100 ms.
// R12: After overcurrent shutdown, fault line low for first 50 ms.
// R13: Load short persisting causes a restart attempt every 100 ms.
// R14: Output short to rail holds stage off until removed, no retries.
// R15: Sleep to Mute checks outputs for rail shorts before enabling stages.
// R16: Every restart repeats the rail short check.
// R17: Supply below 10 V shuts down silently; restart 100 ms after recovery.
// R18: Supply above 36 V shuts down; restart 100 ms after it drops.
// R19: Supply imbalance trips protection until it recovers.
// R20: Fault line pulled low on any protection trip except gain backoff.
// R21: External low on fault line forces Fault mode.
// R22: Comparators synchronised; all timers count internal clock cycles.
// R23: Periodic restart for load short and supply faults; rail short waits.
module amp_mode_protection_sequencer #(
   parameter RESTART_CYC = `T_RESTART_MS * `CLK_KHZ,
   parameter FLAG_CYC = `T_FLAG_MS * `CLK_KHZ
) (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // APB slave
   input wire [11:0] paddr,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Mode pins
   input wire wake_request,
   input wire unmute_request,
   // Open-drain fault line
   input wire fault_line_n_in,
   output reg fault_line_n_out,
   output reg fault_line_n_oe,
   // Carrier setting and sync pin
   input wire [7:0] freq_set_resistor,
   input wire carrier_sync_io_in,
   output reg carrier_sync_io_out,
   output reg carrier_sync_io_oe,
   // Protection comparators
   input wire temp_warn,
   input wire temp_crit,
   input wire i_limit,
   input wire i_short,
   input wire out_rail_short,
   input wire vsup_low,
   input wire vsup_high,
   input wire unbalance,
   // Power stage control
   output reg power_stage_en,
   output reg audio_en,
   output reg [7:0] vi_bias,
   output reg [7:0] gain_level,
   output reg current_limit,
   output reg carrier,
   output reg thermal_gain_backoff,
   output reg [1:0] mode
);
   // ****************************************
   // Constants
   // ****************************************
   localparam [31:0] RESTART_W = RESTART_CYC;
   localparam [31:0] FLAG_W = FLAG_CYC;
   localparam [21:0] RESTART_N = RESTART_W[21:0];
   localparam [21:0] FLAG_N = FLAG_W[21:0];
   localparam [2:0] S_SLEEP = 3'h0;
   localparam [2:0] S_CHECK = 3'h1;
   localparam [2:0] S_RUN = 3'h2;
   localparam [2:0] S_SHUT = 3'h3;
   localparam [2:0] S_OPEN = 3'h4;
   localparam [2:0] S_FAULT = 3'h5;

   // ****************************************
   // Input synchronisation
   // ****************************************
   wire [11:0] sq;
   wire [7:0] rsyn;

   // Mode pins, fault line, sync pin and comparators cross in here [R22]
   sync_2ff #(.W(12), .RST_VAL(12'h400)) u_sync_pins (
      .core_clk(core_clk),
      .rst(rst),
      .d({carrier_sync_io_in, fault_line_n_in, unmute_request, wake_request,
          unbalance, vsup_high, vsup_low, out_rail_short, i_short, i_limit,
          temp_crit, temp_warn}),
      .q(sq)
   );

   // Resistor code is a static strap, sampled like any pin
   sync_2ff #(.W(8), .RST_VAL(8'h00)) u_sync_rosc (
      .core_clk(core_clk),
      .rst(rst),
      .d(freq_set_resistor),
      .q(rsyn)
   );

   wire over_temp_warn = sq[0];
   wire over_temp_crit = sq[1];
   wire load_limit = sq[2];
   wire overcurrent_guard = sq[3];
   wire rail_short = sq[4];
   wire supply_low_guard = sq[5];
   wire supply_high_guard = sq[6];
   wire unbalance_guard = sq[7];
   wire wake = sq[8];
   wire unmute = sq[9];
   wire line_n = sq[10];
   wire sync_in = sq[11];

   // ****************************************
   // Control register
   // ****************************************
   reg [31:0] ctrl_q;
   wire hold_off = ctrl_q[`CTRL_HOLD];
   wire backoff_en = ctrl_q[`CTRL_BACKOFF];

   // ****************************************
   // Carrier generator
   // ****************************************
   reg [8:0] period_q;
   reg [8:0] car_cnt_q;
   reg master_q;
   reg sync_prev_q;
   reg [7:0] step_cnt_q;
   wire [18:0] car_prod = {11'h000, rsyn} * `CAR_K;
   wire [8:0] per_raw = car_prod[18:10];
   wire sync_edge = sync_in & ~sync_prev_q;
   wire tick = (car_cnt_q == 9'h000);
   wire step = tick & (step_cnt_q == 8'hff);

   // Period in clocks from resistance, clamped to the legal band [R6]
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         period_q <= `CAR_MAX;
         master_q <= 1'b0;
      end
      else
      begin
         if (per_raw < `CAR_MIN)
            period_q <= `CAR_MIN;
         else if (per_raw > `CAR_MAX)
            period_q <= `CAR_MAX;
         else
            period_q <= per_raw;
         master_q <= (rsyn > `MASTER_MIN_KOHM); // [R7]
      end
   end

   // Slave restarts its count on each sync edge [R7]
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         car_cnt_q <= 9'h000;
         sync_prev_q <= 1'b0;
         step_cnt_q <= 8'h00;
         carrier <= 1'b0;
         carrier_sync_io_out <= 1'b0;
         carrier_sync_io_oe <= 1'b0;
      end
      else
      begin
         sync_prev_q <= sync_in;
         if (!master_q && sync_edge)
            car_cnt_q <= 9'h000;
         else if (car_cnt_q >= period_q - 9'h001)
            car_cnt_q <= 9'h000;
         else
            car_cnt_q <= car_cnt_q + 9'h001;
         if (tick)
            step_cnt_q <= step_cnt_q + 8'h01;
         carrier <= (car_cnt_q < {1'b0, period_q[8:1]}); // 50 % idle duty [R3]
         carrier_sync_io_out <= carrier; // [R7]
         carrier_sync_io_oe <= master_q; // [R7]
      end
   end

   // ****************************************
   // Mode and protection sequencer
   // ****************************************
   reg [2:0] state_q;
   reg [21:0] timer_q;
   reg [7:0] chk_cnt_q;
   reg oc_trip_q;
   reg [2:0] oe_hist_q;
   wire own_drive = fault_line_n_oe | (|oe_hist_q);
   // Our own pull is masked until it has cleared the synchroniser
   wire ext_fault = wake & ~line_n & ~own_drive; // [R21]
   wire hard_fault = over_temp_crit | supply_low_guard | supply_high_guard
                     | unbalance_guard;
   wire go_sleep = ~wake | hold_off;

   always @(posedge core_clk)
   begin
      if (rst)
      begin
         state_q <= S_SLEEP;
         timer_q <= 22'h000000;
         chk_cnt_q <= 8'h00;
         oc_trip_q <= 1'b0;
      end
      else if (go_sleep)
      begin
         state_q <= S_SLEEP; // [R2]
         oc_trip_q <= 1'b0;
      end
      else if (ext_fault)
         state_q <= S_FAULT; // [R21] [R2]
      else
      begin
         case (state_q)
            S_SLEEP:
            begin
               state_q <= S_CHECK; // Check before any switching [R15]
               chk_cnt_q <= 8'h00;
            end
            S_CHECK:
            begin
               chk_cnt_q <= chk_cnt_q + 8'h01;
               if (rail_short)
                  state_q <= S_OPEN; // [R15] [R16]
               else if (hard_fault)
               begin
                  state_q <= S_SHUT; // Load current judged only once switching [R13]
                  timer_q <= 22'h000000;
                  oc_trip_q <= 1'b0;
               end
               else if (chk_cnt_q == `T_CHECK_CYC)
                  state_q <= S_RUN;
            end
            S_RUN:
            begin
               timer_q <= 22'h000000;
               if (rail_short)
                  state_q <= S_OPEN; // No periodic retry [R14] [R23]
               else if (hard_fault)
               begin
                  state_q <= S_SHUT; // [R9] [R17] [R18] [R19]
                  oc_trip_q <= 1'b0;
               end
               else if (overcurrent_guard)
               begin
                  state_q <= S_SHUT; // [R11]
                  oc_trip_q <= 1'b1;
               end
            end
            S_SHUT:
            begin
               // Timer holds at zero while a supply or heat fault lasts
               if (hard_fault)
                  timer_q <= 22'h000000; // [R17] [R18] [R19] [R23]
               else if (timer_q == RESTART_N - 22'h000001)
               begin
                  state_q <= S_CHECK; // Retry every 100 ms [R11] [R13] [R16]
                  chk_cnt_q <= 8'h00;
               end
               else
                  timer_q <= timer_q + 22'h000001;
            end
            S_OPEN:
            begin
               if (!rail_short)
               begin
                  state_q <= S_CHECK; // Recheck once removed [R14] [R16]
                  chk_cnt_q <= 8'h00;
                  oc_trip_q <= 1'b0;
               end
            end
            S_FAULT:
            begin
               state_q <= S_CHECK;
               chk_cnt_q <= 8'h00;
            end
            default:
               state_q <= S_SLEEP;
         endcase
      end
   end

   // ****************************************
   // Fault line drive
   // ****************************************
   // Overcurrent pulls low only for the first 50 ms of its timer
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         fault_line_n_out <= 1'b0;
         fault_line_n_oe <= 1'b0;
         oe_hist_q <= 3'h0;
      end
      else
      begin
         fault_line_n_out <= 1'b0;
         oe_hist_q <= {oe_hist_q[1:0], fault_line_n_oe};
         if (state_q == S_OPEN)
            fault_line_n_oe <= 1'b1; // [R20]
         else if (state_q == S_SHUT && oc_trip_q)
            fault_line_n_oe <= (timer_q < FLAG_N); // [R12]
         else
            fault_line_n_oe <= (state_q == S_SHUT); // [R20]
      end
   end

   // ****************************************
   // Power stage, bias and gain
   // ****************************************
   wire running = (state_q == S_RUN);
   wire bias_up = running & unmute;

   // Bias walks one step per carrier period, avoiding a hard edge [R5]
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         power_stage_en <= 1'b0;
         audio_en <= 1'b0;
         vi_bias <= 8'h00;
         current_limit <= 1'b0;
         mode <= `MODE_SLEEP;
      end
      else
      begin
         power_stage_en <= running; // Mute still switches [R3] [R4]
         audio_en <= bias_up; // Converters off in Mute [R3] [R4]
         if (!running)
            vi_bias <= 8'h00; // Silent shutdown [R17]
         else if (tick && bias_up && vi_bias != `BIAS_MAX)
            vi_bias <= vi_bias + 8'h01; // [R5]
         else if (tick && !bias_up && vi_bias != 8'h00)
            vi_bias <= vi_bias - 8'h01; // [R5]
         current_limit <= running & load_limit; // Audio keeps flowing [R10]
         if (state_q == S_SLEEP)
            mode <= `MODE_SLEEP; // [R1]
         else if (state_q == S_RUN)
            mode <= unmute ? `MODE_OPER : `MODE_MUTE; // [R1] [R2]
         else if (state_q == S_CHECK)
            mode <= `MODE_MUTE;
         else
            mode <= `MODE_FAULT; // [R1]
      end
   end

   // Slow gain fold toward the 140 C threshold, no fault line [R8] [R20]
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         gain_level <= `GAIN_MAX;
         thermal_gain_backoff <= 1'b0;
      end
      else
      begin
         if (!backoff_en)
            gain_level <= `GAIN_MAX;
         else if (step && over_temp_warn && gain_level > `GAIN_MIN)
            gain_level <= gain_level - 8'h01; // [R8]
         else if (step && !over_temp_warn && gain_level != `GAIN_MAX)
            gain_level <= gain_level + 8'h01; // [R8]
         thermal_gain_backoff <= (gain_level != `GAIN_MAX);
      end
   end

   // ****************************************
   // APB slave
   // ****************************************
   wire setup = psel & ~penable;
   wire wr_done = psel & penable & pready & pwrite;
   wire [31:0] status = {1'b0, sq[7:0], vi_bias, gain_level, oc_trip_q,
                         master_q, mode, state_q};

   // Answer registered in setup, so access never waits
   always @(posedge core_clk)
   begin
      if (rst)
      begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         ctrl_q <= `CTRL_RST;
      end
      else
      begin
         pready <= setup & ~pready;
         if (setup && !pready)
         begin
            pslverr <= 1'b0;
            case (paddr)
               `CTRL_OFS:
                  prdata <= ctrl_q;
               `STATUS_OFS:
                  prdata <= status;
               `RATE_OFS:
                  prdata <= {23'h000000, period_q};
               default:
               begin
                  prdata <= 32'h0000_0000;
                  pslverr <= 1'b1;
               end
            endcase
         end
         else if (!psel)
            pslverr <= 1'b0;
         if (wr_done && paddr == `CTRL_OFS)
            ctrl_q <= pwdata & `CTRL_MASK;
      end
   end
endmodule

// >>> tb/amp_host_model.sv
`timescale 1ns/1ns
// ****************************************
// Host side: mode pins and fault line
// ****************************************
module amp_host_model (
   // Clock
   input wire core_clk,
   // Bench commands
   input wire wake_cmd,
   input wire unmute_cmd,
   input wire pull_cmd,
   // Device side
   input wire fault_line_n_out,
   input wire fault_line_n_oe,
   output reg wake_request,
   output reg unmute_request,
   output wire fault_line_n_in
);
   // Pins start low so the device sleeps
   initial
   begin
      wake_request = 1'b0;
      unmute_request = 1'b0;
   end
   // Pins move just after the edge; unmute is stepped, not ramped
   always @(posedge core_clk)
   begin
      wake_request <= wake_cmd;
      unmute_request <= unmute_cmd;
   end
   // Pull-up wins unless some party pulls low
   assign fault_line_n_in = ((fault_line_n_oe && !fault_line_n_out) || pull_cmd) ? 1'b0 : 1'b1;
endmodule

// >>> tb/amp_seq_sva.sv
`timescale 1ns/1ns
`include "amp_seq_map.vh"
// ****************************************
// Port checker
// ****************************************
module amp_seq_sva (
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Watched ports
   input wire [7:0] freq_set_resistor,
   input wire fault_line_n_out,
   input wire fault_line_n_oe,
   input wire carrier_sync_io_oe,
   input wire power_stage_en,
   input wire audio_en,
   input wire [7:0] vi_bias,
   input wire [7:0] gain_level,
   input wire current_limit,
   input wire [1:0] mode
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // Strap needs a few edges through the synchroniser
   a_line_low_only: assert property (fault_line_n_out == 1'b0)
      else $error("fault line driven high");
   a_master_drive: assert property ((!rst && $stable(freq_set_resistor)) [*6] |->
      carrier_sync_io_oe == (freq_set_resistor > `MASTER_MIN_KOHM))
      else $error("sync pin direction wrong");
   a_audio_in_run: assert property (audio_en |-> power_stage_en)
      else $error("audio without power stage");
   a_bias_off: assert property (!power_stage_en |-> vi_bias == 8'h00)
      else $error("bias not zero out of run");
   a_sleep_quiet: assert property (mode == `MODE_SLEEP |-> !power_stage_en)
      else $error("power stage on in sleep");
   a_limit_run: assert property (current_limit |-> power_stage_en)
      else $error("current limit out of run");
   a_gain_step: assert property ($changed(gain_level) |->
      (gain_level - $past(gain_level) == 8'h01 || $past(gain_level) - gain_level == 8'h01))
      else $error("gain jumped");
   a_gain_hold: assert property ($changed(gain_level) |=> $stable(gain_level) [*8])
      else $error("gain stepped too fast");
   a_flag_off: assert property (fault_line_n_oe && $past(fault_line_n_oe) |-> !power_stage_en)
      else $error("fault flagged while running");
   a_fault_off: assert property (mode == `MODE_FAULT && $past(mode) == `MODE_FAULT
      |-> !power_stage_en)
      else $error("power stage on in fault");
   // Main scenarios reached
   c_audio: cover property ($rose(audio_en));
   c_flag: cover property ($rose(fault_line_n_oe));
   c_backoff: cover property ($fell(gain_level == `GAIN_MAX));
endmodule

bind amp_mode_protection_sequencer amp_seq_sva i_sva (
   .core_clk(core_clk),
   .rst(rst),
   .freq_set_resistor(freq_set_resistor),
   .fault_line_n_out(fault_line_n_out),
   .fault_line_n_oe(fault_line_n_oe),
   .carrier_sync_io_oe(carrier_sync_io_oe),
   .power_stage_en(power_stage_en),
   .audio_en(audio_en),
   .vi_bias(vi_bias),
   .gain_level(gain_level),
   .current_limit(current_limit),
   .mode(mode)
);

// >>> tb/test_amp_mode_protection_sequencer.sv
`timescale 1ns/1ns
`include "amp_seq_map.vh"
module test_amp_mode_protection_sequencer;
   // ****************************************
   // Signals
   // ****************************************
   localparam int RESTART = 200;
   localparam int FLAG = 100;
   reg core_clk = 1'b0;
   reg rst = 1'b1;
   reg [11:0] paddr = 12'h000;
   reg psel = 1'b0;
   reg penable = 1'b0;
   reg pwrite = 1'b0;
   reg [31:0] pwdata = 32'h0000_0000;
   reg wake_cmd = 1'b0;
   reg unmute_cmd = 1'b0;
   reg pull_cmd = 1'b0;
   reg sync_ext = 1'b0;
   reg [7:0] freq_set_resistor = 8'h27;
   reg [7:0] cmp = 8'h00;
   reg [31:0] rd;
   reg er;
   wire [31:0] prdata;
   wire [7:0] vi_bias, gain_level;
   wire [1:0] mode;
   wire pready, pslverr, wake_request, unmute_request, fault_line_n_in;
   wire fault_line_n_out, fault_line_n_oe, carrier_sync_io_out, carrier_sync_io_oe;
   wire power_stage_en, audio_en, current_limit, carrier, thermal_gain_backoff;
   integer err_total = 0;
   integer n_compared = 0;
   integer n, t, f, b;
   // Short timers keep the run brief
   amp_mode_protection_sequencer #(.RESTART_CYC(RESTART), .FLAG_CYC(FLAG)) i_dut (
      .core_clk(core_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .wake_request(wake_request), .unmute_request(unmute_request),
      .fault_line_n_in(fault_line_n_in), .fault_line_n_out(fault_line_n_out),
      .fault_line_n_oe(fault_line_n_oe), .freq_set_resistor(freq_set_resistor),
      .carrier_sync_io_in(carrier_sync_io_oe ? carrier_sync_io_out : sync_ext),
      .carrier_sync_io_out(carrier_sync_io_out),
      .carrier_sync_io_oe(carrier_sync_io_oe), .temp_warn(cmp[0]), .temp_crit(cmp[1]),
      .i_limit(cmp[2]), .i_short(cmp[3]), .out_rail_short(cmp[4]), .vsup_low(cmp[5]),
      .vsup_high(cmp[6]), .unbalance(cmp[7]), .power_stage_en(power_stage_en),
      .audio_en(audio_en), .vi_bias(vi_bias), .gain_level(gain_level),
      .current_limit(current_limit), .carrier(carrier),
      .thermal_gain_backoff(thermal_gain_backoff), .mode(mode));
   amp_host_model i_host (
      .core_clk(core_clk), .wake_cmd(wake_cmd), .unmute_cmd(unmute_cmd),
      .pull_cmd(pull_cmd), .fault_line_n_out(fault_line_n_out),
      .fault_line_n_oe(fault_line_n_oe), .wake_request(wake_request),
      .unmute_request(unmute_request), .fault_line_n_in(fault_line_n_in));
   // 20 MHz clock
   always #25 core_clk = ~core_clk;
   // ****************************************
   // Shared tasks
   // ****************************************
   task report_and_stop;
   begin
      if (err_total == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   end
   endtask
   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
         err_total = err_total + 1;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   // Bounded waits end the run on a hang
   task hang;
   begin
      err_total = err_total + 1;
      report_and_stop;
   end
   endtask
   // APB master: hold the request until pready is seen high
   task apb(input w, input [11:0] a, input [31:0] d);
   begin
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge core_clk);
      while (pready !== 1'b1 && n < 20)
      begin
         @(posedge core_clk);
         n = n + 1;
      end
      if (pready !== 1'b1)
         hang;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end
   endtask
   task wait_pwr(input v, input integer lim);
   begin
      n = 0;
      while (power_stage_en !== v && n < lim)
      begin
         @(posedge core_clk);
         n = n + 1;
      end
      if (power_stage_en !== v)
         hang;
   end
   endtask
   // Cycles off until restart, and cycles the line is pulled
   task off_time;
   begin
      t = 0;
      f = 0;
      while (power_stage_en !== 1'b1 && t < 1000)
      begin
         if (fault_line_n_oe === 1'b1)
            f = f + 1;
         @(posedge core_clk);
         t = t + 1;
      end
      if (power_stage_en !== 1'b1)
         hang;
   end
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task s_startup;
   begin
      chk(mode, `MODE_SLEEP);
      apb(1'b0, `CTRL_OFS, 32'h0);
      chk(rd, `CTRL_RST);
      apb(1'b0, 12'h00c, 32'h0);
      chk({er, rd[30:0]}, 32'h8000_0000);
      apb(1'b1, `CTRL_OFS, 32'h3);
      wake_cmd <= 1'b1;
      repeat (60) @(posedge core_clk);
      chk(power_stage_en, 1'b0);
      apb(1'b1, `CTRL_OFS, `CTRL_RST);
      wait_pwr(1'b1, 200);
      chk({mode, audio_en}, {`MODE_MUTE, 1'b0});
      apb(1'b0, `RATE_OFS, 32'h0);
      chk(rd, 32'h3e);
      chk(carrier_sync_io_oe, 1'b1);
      unmute_cmd <= 1'b1;
      repeat (200) @(posedge core_clk);
      chk({mode, audio_en}, {`MODE_OPER, 1'b1});
      chk(vi_bias > 8'h00 && vi_bias < 8'h10, 1'b1);
      cmp[2] <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk(current_limit & audio_en, 1'b1);
      cmp[2] <= 1'b0;
   end
   endtask
   task s_rail;
   begin
      wake_cmd <= 1'b0;
      wait_pwr(1'b0, 20);
      chk(mode, `MODE_SLEEP);
      cmp[4] <= 1'b1;
      wake_cmd <= 1'b1;
      repeat (300) @(posedge core_clk);
      chk({power_stage_en, fault_line_n_oe}, 2'b01);
      cmp[4] <= 1'b0;
      wait_pwr(1'b1, 100);
      cmp[4] <= 1'b1;
      cmp[3] <= 1'b1;
      wait_pwr(1'b0, 20);
      cmp[3] <= 1'b0;
      repeat (3 * RESTART) @(posedge core_clk);
      chk(power_stage_en, 1'b0);
      cmp[4] <= 1'b0;
      wait_pwr(1'b1, 100);
   end
   endtask
   task s_overcurrent;
   begin
      cmp[3] <= 1'b1;
      wait_pwr(1'b0, 20);
      cmp[3] <= 1'b0;
      off_time;
      chk(f >= FLAG && f <= FLAG + 2, 1'b1);
      chk(t >= RESTART && t < RESTART + 100, 1'b1);
      cmp[3] <= 1'b1;
      wait_pwr(1'b0, 20);
      wait_pwr(1'b1, RESTART + 100);
      wait_pwr(1'b0, 40);
      cmp[3] <= 1'b0;
      wait_pwr(1'b1, RESTART + 100);
   end
   endtask
   // Over-temperature and the three supply guards share one restart policy
   task s_supply;
   begin
      for (b = 1; b < 8; b = b + 1)
         if (b == 1 || b > 4)
         begin
            cmp[b] <= 1'b1;
            wait_pwr(1'b0, 20);
            repeat (300) @(posedge core_clk);
            chk({power_stage_en, fault_line_n_oe}, 2'b01);
            cmp[b] <= 1'b0;
            off_time;
            chk(t >= RESTART && t < RESTART + 100, 1'b1);
         end
   end
   endtask
   task s_extfault;
   begin
      pull_cmd <= 1'b1;
      repeat (8) @(posedge core_clk);
      chk({mode, power_stage_en}, {`MODE_FAULT, 1'b0});
      pull_cmd <= 1'b0;
      wait_pwr(1'b1, 100);
   end
   endtask
   task s_thermal;
   begin
      cmp[0] <= 1'b1;
      n = 0;
      while (thermal_gain_backoff !== 1'b1 && n < 20000)
      begin
         @(posedge core_clk);
         n = n + 1;
      end
      chk({thermal_gain_backoff, power_stage_en}, 2'b11);
      apb(1'b0, `STATUS_OFS, 32'h0);
      chk({rd[30:23], rd[14:7], rd[4:3]}, {8'h01, 8'hfe, `MODE_OPER});
      cmp[0] <= 1'b0;
   end
   endtask
   // Shorted resistor: slave at the fastest carrier, then locked to sync edges
   task s_slave;
   begin
      freq_set_resistor <= 8'h00;
      repeat (60) @(posedge core_clk);
      chk(carrier_sync_io_oe, 1'b0);
      apb(1'b0, `RATE_OFS, 32'h0);
      chk(rd, `CAR_MIN);
      f = 0;
      t = 0;
      for (b = 0; b < 200; b = b + 1)
      begin
         if (b >= 80)
            sync_ext <= (b % 30) < 15;
         @(posedge core_clk);
         if (b < 80)
            f = f + carrier;
         else if (b >= 140)
            t = t + carrier;
      end
      chk(f, 40);
      chk(t, 40);
   end
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst <= 1'b0;
      s_startup;
      s_rail;
      s_overcurrent;
      s_supply;
      s_extfault;
      s_thermal;
      s_slave;
      report_and_stop;
   end
endmodule
